// ===== core/window_watchdog_timer.sv
// Function
// - 7-bit counter decrements every 16384 clocks
// - reset when counter rolls 40h to 3Fh
// - activate bit set by software only
// - hardware option forces watchdog active
// - window limit seven bits, bit7 reads zero
// - both registers reset to 7Fh
// - timebase selects upper/lower constants
// - minimum timeout computed from constants
// - maximum timeout computed from constants
// - divisions truncate to integers
// - slow and wait keep normal counting
// - plain halt: one decrement then stop
// - wake interrupt resumes after delay
// - reset from halt restores disabled state unless hardware option set
// - halt-reset option resets instead of halting
// - active-halt: no reset, no counting
// - active-halt wake: immediate or delayed
// - early reload above window resets
// - software option: disabled until activated
// - counter runs even while disabled
//
// The implementer's own choice: the strobed register port.
module window_watchdog_timer
    import wwdg_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_CYCLES,
    parameter int WAKE_LONG = WAKE_LONG_CLOCKS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    // options and power control
    input wire logic hwWatchdogOption,
    input wire logic haltResetOption,
    input wire logic oscillatorIrqEnable,
    input wire logic [1:0] timebaseSelect,
    input wire logic wakeLongDelay,
    input wire logic haltRequest,
    input wire logic wakeInterrupt,
    input wire logic resetFromHalt,
    // status and timeout figures
    output logic [31:0] timeoutMin,
    output logic [31:0] timeoutMax,
    output logic watchdogActive,
    // system
    output logic resetRequest
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [6:0] syncA_ff;
    logic [6:0] syncB_ff;
    logic hwOpt;
    logic haltOpt;
    logic oieSync;
    logic longSync;
    logic haltReq;
    logic wakeIrq;
    logic resetWake;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            syncA_ff <= '0;
            syncB_ff <= '0;
        end else begin
            syncA_ff <= {hwWatchdogOption, haltResetOption, oscillatorIrqEnable, wakeLongDelay,
                         haltRequest, wakeInterrupt, resetFromHalt};
            syncB_ff <= syncA_ff;
        end
    end

    assign {hwOpt, haltOpt, oieSync, longSync, haltReq, wakeIrq, resetWake} = syncB_ff;

    // ****************************************
    // registers and state
    // ****************************************
    logic activate_ff;
    logic [6:0] count_ff;
    logic [6:0] window_ff;
    logic [13:0] prescale_ff;
    logic tick;
    pwr_e pwr_ff;
    logic [12:0] wakeCnt_ff;
    logic enabled;
    logic counting;
    logic ctrlWrite;
    logic earlyReload;
    logic rollOver;
    logic haltResetHit;

    assign enabled = hwOpt | activate_ff;
    assign watchdogActive = enabled;
    assign ctrlWrite = regWrite && (regAddr == ADDR_CONTROL);
    assign earlyReload = ctrlWrite && (count_ff > window_ff);
    assign counting = (pwr_ff == PWR_RUN) || (pwr_ff == PWR_HALT_STEP);
    assign haltResetHit = haltReq && !oieSync && haltOpt && enabled && (pwr_ff == PWR_RUN);
    assign rollOver = tick && counting && !ctrlWrite && (count_ff == ROLL_FROM);

    // free prescaler, never cleared by writes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prescale_ff <= '0;
        end else if (prescale_ff == 14'(PRESCALE - 1)) begin
            prescale_ff <= '0;
        end else begin
            prescale_ff <= prescale_ff + 14'd1;
        end
    end

    assign tick = (prescale_ff == 14'(PRESCALE - 1));

    // activate bit: set only by software
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            activate_ff <= CONTROL_RESET[ACTIVATE_POS];
        end else if (resetWake && !hwOpt && pwr_ff != PWR_RUN) begin
            activate_ff <= 1'b0;
        end else if (ctrlWrite && regWdata[ACTIVATE_POS]) begin
            activate_ff <= 1'b1;
        end
    end

    // countdown, free-running even when disabled
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= CONTROL_RESET[6:0];
        end else if (resetWake && !hwOpt && pwr_ff != PWR_RUN) begin
            count_ff <= CONTROL_RESET[6:0];
        end else if (ctrlWrite) begin
            count_ff <= regWdata[6:0];
        end else if (tick && counting) begin
            count_ff <= count_ff - 7'd1;
        end
    end

    // window limit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            window_ff <= WINDOW_RESET;
        end else if (regWrite && regAddr == ADDR_WINDOW) begin
            window_ff <= regWdata[6:0];
        end
    end

    // ****************************************
    // low-power tracking
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwr_ff <= PWR_RUN;
            wakeCnt_ff <= '0;
        end else begin
            case (pwr_ff)
                PWR_RUN: begin
                    if (haltReq && !haltResetHit) begin
                        pwr_ff <= oieSync ? PWR_FROZEN : PWR_HALT_STEP;
                    end
                end
                PWR_HALT_STEP: begin
                    if (tick) begin
                        pwr_ff <= PWR_FROZEN;
                    end
                end
                PWR_FROZEN: begin
                    if (wakeIrq && oieSync) begin
                        pwr_ff <= PWR_RUN;
                    end else if (wakeIrq || resetWake) begin
                        pwr_ff <= PWR_WAKE;
                        wakeCnt_ff <= longSync ? 13'(WAKE_LONG - 1) : 13'(WAKE_SHORT_CLOCKS - 1);
                    end
                end
                PWR_WAKE: begin
                    if (wakeCnt_ff == '0) begin
                        pwr_ff <= PWR_RUN;
                    end else begin
                        wakeCnt_ff <= wakeCnt_ff - 13'd1;
                    end
                end
                default: begin
                    pwr_ff <= PWR_RUN;
                end
            endcase
        end
    end

    // ****************************************
    // reset request, the only system output
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            resetRequest <= 1'b0;
        end else begin
            resetRequest <= enabled && (rollOver || earlyReload || haltResetHit);
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= '0;
        end else if (regRead) begin
            case (regAddr)
                ADDR_CONTROL: regRdata <= {activate_ff, count_ff};
                ADDR_WINDOW: regRdata <= {1'b0, window_ff};
                default: regRdata <= '0;
            endcase
        end
    end

    // ****************************************
    // timeout figures in oscillator periods
    // ****************************************
    logic [31:0] upper;
    logic [31:0] lower;
    logic [31:0] steps;
    logic [31:0] quarter;
    logic [31:0] groups;
    logic [31:0] stepTerm;
    logic [31:0] longTerm;

    always_comb begin
        upper = 32'(TB_UPPER[timebaseSelect]);
        lower = 32'(TB_LOWER[timebaseSelect]);
        steps = 32'(count_ff[5:0]);
        quarter = upper / 32'd4;
        groups = (32'd4 * steps) / upper;
        stepTerm = 32'(PRESCALE_CYCLES) * steps;
        longTerm = 32'(PRESCALE_CYCLES) * (steps - groups) + 32'(STEP_ADD) * 32'(STEP_SCALE) * groups
                 + lower * 32'(STEP_SCALE) * groups;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timeoutMin <= '0;
            timeoutMax <= '0;
        end else begin
            timeoutMin <= (lower + 32'(BASE_ADD)) * 32'(STEP_SCALE) + ((steps < quarter) ? stepTerm : longTerm);
            timeoutMax <= 32'(PRESCALE_CYCLES) + ((steps <= quarter) ? stepTerm : longTerm);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_roll;
        enabled && rollOver;
    endsequence

    property p_roll_reset;
        @(posedge clk_sys) disable iff (!rst_n) s_roll |=> resetRequest;
    endproperty
    a_roll_reset: assert property (p_roll_reset) else $error("no reset on rollover");

    property p_early;
        @(posedge clk_sys) disable iff (!rst_n) (enabled && ctrlWrite && count_ff > window_ff) |=> resetRequest;
    endproperty
    a_early: assert property (p_early) else $error("no reset on early reload");

    property p_no_spurious;
        @(posedge clk_sys) disable iff (!rst_n) !enabled |=> !resetRequest;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("reset while disabled");

    property p_activate_sticky;
        @(posedge clk_sys) disable iff (!rst_n) (activate_ff && !resetWake) |=> activate_ff;
    endproperty
    a_activate_sticky: assert property (p_activate_sticky) else $error("activate bit dropped");

    property p_decrement;
        @(posedge clk_sys) disable iff (!rst_n) (tick && counting && !ctrlWrite && !resetWake)
            |=> count_ff == $past(count_ff) - 7'd1;
    endproperty
    a_decrement: assert property (p_decrement) else $error("counter missed a step");

    property p_frozen;
        @(posedge clk_sys) disable iff (!rst_n) (pwr_ff == PWR_FROZEN && !regWrite && !resetWake) |=> $stable(count_ff);
    endproperty
    a_frozen: assert property (p_frozen) else $error("counter moved in halt");

    property p_window_read;
        @(posedge clk_sys) disable iff (!rst_n) (regRead && regAddr == ADDR_WINDOW) |=> !regRdata[7];
    endproperty
    a_window_read: assert property (p_window_read) else $error("reserved bit set");

    property p_hw_active;
        @(posedge clk_sys) disable iff (!rst_n) hwOpt |-> watchdogActive;
    endproperty
    a_hw_active: assert property (p_hw_active) else $error("hardware option not active");

    property p_halt_reset;
        @(posedge clk_sys) disable iff (!rst_n) haltResetHit |=> resetRequest ##1 pwr_ff == PWR_RUN;
    endproperty
    a_halt_reset: assert property (p_halt_reset) else $error("halt-reset missing");

    // ****************************************
    // low-power and free-run checks
    // ****************************************
    sequence s_halt_entry;
        pwr_ff == PWR_RUN && haltReq && !haltResetHit && !oieSync;
    endsequence

    sequence s_single_step;
        pwr_ff == PWR_HALT_STEP && tick;
    endsequence

    sequence s_wake_start;
        pwr_ff == PWR_FROZEN && !(wakeIrq && oieSync) && (wakeIrq || resetWake);
    endsequence

    property p_halt_step;
        @(posedge clk_sys) disable iff (!rst_n) s_halt_entry |=> pwr_ff == PWR_HALT_STEP;
    endproperty
    a_halt_step: assert property (p_halt_step) else $error("plain halt not entered");

    property p_halt_stop;
        @(posedge clk_sys) disable iff (!rst_n) s_single_step |=> pwr_ff == PWR_FROZEN;
    endproperty
    a_halt_stop: assert property (p_halt_stop) else $error("halt step did not stop");

    property p_active_halt;
        @(posedge clk_sys) disable iff (!rst_n) (pwr_ff == PWR_RUN && haltReq && oieSync) |=> pwr_ff == PWR_FROZEN;
    endproperty
    a_active_halt: assert property (p_active_halt) else $error("active halt not entered");

    property p_frozen_quiet;
        @(posedge clk_sys) disable iff (!rst_n) (pwr_ff == PWR_FROZEN && !regWrite) |=> !resetRequest;
    endproperty
    a_frozen_quiet: assert property (p_frozen_quiet) else $error("reset while halted");

    property p_wake_now;
        @(posedge clk_sys) disable iff (!rst_n) (pwr_ff == PWR_FROZEN && wakeIrq && oieSync) |=> counting;
    endproperty
    a_wake_now: assert property (p_wake_now) else $error("active halt wake delayed");

    property p_wake_delay;
        @(posedge clk_sys) disable iff (!rst_n) s_wake_start |=> pwr_ff == PWR_WAKE && !counting
            && wakeCnt_ff == ($past(longSync) ? 13'(WAKE_LONG - 1) : 13'(WAKE_SHORT_CLOCKS - 1));
    endproperty
    a_wake_delay: assert property (p_wake_delay) else $error("wake delay not loaded");

    property p_wake_hold;
        @(posedge clk_sys) disable iff (!rst_n) (pwr_ff == PWR_WAKE && wakeCnt_ff != '0) |=> !counting;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("counting during wake delay");

    property p_wake_end;
        @(posedge clk_sys) disable iff (!rst_n) (pwr_ff == PWR_WAKE && wakeCnt_ff == '0) |=> counting;
    endproperty
    a_wake_end: assert property (p_wake_end) else $error("counting not resumed");

    property p_halt_clear;
        @(posedge clk_sys) disable iff (!rst_n) (resetWake && !hwOpt && pwr_ff != PWR_RUN) |=> !activate_ff && count_ff == CONTROL_RESET[6:0];
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("halt reset kept state");

    property p_free_run;
        @(posedge clk_sys) disable iff (!rst_n) (!enabled && tick && counting && !ctrlWrite && !resetWake)
            |=> count_ff == $past(count_ff) - 7'h01;
    endproperty
    a_free_run: assert property (p_free_run) else $error("counter idle while disabled");

    property p_prescale_free;
        @(posedge clk_sys) disable iff (!rst_n) (ctrlWrite && !tick) |=> prescale_ff == $past(prescale_ff) + 14'h0001;
    endproperty
    a_prescale_free: assert property (p_prescale_free) else $error("prescaler disturbed by write");

    property p_activate_set;
        @(posedge clk_sys) disable iff (!rst_n) (ctrlWrite && regWdata[ACTIVATE_POS] && !resetWake) |=> activate_ff;
    endproperty
    a_activate_set: assert property (p_activate_set) else $error("activate bit not set");

endmodule

// ===== core/wwdg_pkg.sv
package wwdg_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_CONTROL = 8'h2a;
    localparam logic [7:0] ADDR_WINDOW = 8'h2b;
    localparam logic [7:0] CONTROL_RESET = 8'h7f;
    localparam logic [6:0] WINDOW_RESET = 7'h7f;
    localparam int ACTIVATE_POS = 7;
    localparam int TOP_POS = 6;
    localparam logic [6:0] ROLL_FROM = 7'h40;
    localparam logic [6:0] ROLL_TO = 7'h3f;

    // ****************************************
    // timing
    // ****************************************
    localparam int PRESCALE_CYCLES = 16384;
    localparam int WAKE_SHORT_CLOCKS = 256;
    localparam int WAKE_LONG_CLOCKS = 4096;

    // (upper, lower) per timebase 2/4/10/25 ms
    localparam logic [7:0] TB_UPPER [4] = '{8'h04, 8'h08, 8'h14, 8'h31};
    localparam logic [7:0] TB_LOWER [4] = '{8'h3b, 8'h35, 8'h23, 8'h36};
    localparam int BASE_ADD = 128;
    localparam int STEP_ADD = 192;
    localparam int STEP_SCALE = 64;

    // ****************************************
    // power state machine
    // ****************************************
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_HALT_STEP = 2'b01,
        PWR_FROZEN = 2'b11,
        PWR_WAKE = 2'b10
    } pwr_e;

endpackage

// ===== sim/power_partner.sv
module power_partner (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // commands from the bench
    input wire logic haltCmd,
    input wire logic wakeCmd,
    input wire logic rstCmd,
    // watchdog side
    input wire logic resetRequest,
    output logic haltRequest,
    output logic wakeInterrupt,
    output logic resetFromHalt,
    output logic [31:0] resCnt
);
    timeunit 1ns;
    timeprecision 1ns;

    // cpu halt control and system reset collector
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            haltRequest <= 1'b0;
            wakeInterrupt <= 1'b0;
            resetFromHalt <= 1'b0;
            resCnt <= '0;
        end else begin
            haltRequest <= haltCmd;
            wakeInterrupt <= wakeCmd;
            resetFromHalt <= rstCmd;
            resCnt <= resCnt + 32'(resetRequest);
        end
    end
endmodule

// ===== sim/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import wwdg_pkg::*;
    localparam int PS = 16;
    logic clk_sys = 0, rst_n = 0, regWrite = 0, regRead = 0, hwWatchdogOption = 0;
    logic haltResetOption = 0, oscillatorIrqEnable = 0, wakeLongDelay = 0, haltRequest;
    logic wakeInterrupt, resetFromHalt, watchdogActive, resetRequest;
    logic haltCmd = 0, wakeCmd = 0, rstCmd = 0;
    logic [1:0] timebaseSelect = 0;
    logic [7:0] regAddr = 0, regWdata = 0, regRdata, d, e;
    logic [31:0] timeoutMin, timeoutMax, resCnt, c0, seed = 2;
    int mismatches = 0, cmp_count = 0;

    window_watchdog_timer #(.PRESCALE(PS), .WAKE_LONG(32)) i_dut (.clk_sys, .rst_n, .regAddr, .regWdata,
        .regWrite, .regRead, .regRdata, .hwWatchdogOption, .haltResetOption, .oscillatorIrqEnable,
        .timebaseSelect, .wakeLongDelay, .haltRequest, .wakeInterrupt, .resetFromHalt, .timeoutMin,
        .timeoutMax, .watchdogActive, .resetRequest);
    power_partner i_cpu (.clk_sys, .rst_n, .haltCmd, .wakeCmd, .rstCmd, .resetRequest, .haltRequest,
        .wakeInterrupt, .resetFromHalt, .resCnt);

    initial forever #25 clk_sys = ~clk_sys;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] tcalc(int c, int t, bit mx);
        int u, l, k, b;
        u = TB_UPPER[t];
        l = TB_LOWER[t];
        k = 4 * c / u;
        b = mx ? 16384 : (l + 128) * 64;
        if (mx ? c <= u / 4 : c < u / 4) return b + 16384 * c;
        return b + 16384 * (c - k) + (192 + l) * 64 * k;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys) {regAddr, regWdata, regWrite} <= {a, v, 1'b1};
        @(posedge clk_sys) regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys) {regAddr, regRead} <= {a, 1'b1};
        @(posedge clk_sys) regRead <= 1'b0;
        @(posedge clk_sys) v = regRdata;
    endtask

    task automatic waitRes(int n);
        repeat (n) begin
            @(posedge clk_sys);
            if (resCnt !== c0) return;
        end
        mismatches++;
        $display("ERROR %0t: reset request missing", $time);
        final_report();
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic hwReset();
        @(posedge clk_sys) rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        cyc(8);
        rst_n <= 1'b1;
        rd(ADDR_CONTROL, d); chk(d, 8'h7f);
        rd(ADDR_WINDOW, d); chk(d, 8'h7f);
        rd(8'h2c, d); chk(d, 0);
        repeat (4) begin
            e = 8'(rnd());
            wr(ADDR_WINDOW, e);
            rd(ADDR_WINDOW, d); chk(d, {1'b0, e[6:0]});
        end
        rd(ADDR_CONTROL, d);
        cyc(PS - 3);
        rd(ADDR_CONTROL, e); chk(d - e, 1);
        c0 = resCnt;
        cyc(70 * PS);
        chk(resCnt, c0);
        rd(ADDR_CONTROL, d); chk(d[7], 0);
        chk(watchdogActive, 0);
        for (int t = 0; t < 4; t++) begin
            timebaseSelect <= 2'(t);
            e = 8'(rnd());
            wr(ADDR_CONTROL, {1'b0, e[6:0]});
            rd(ADDR_CONTROL, d);
            chk(timeoutMin, tcalc(d[5:0], t, 0));
            chk(timeoutMax, tcalc(d[5:0], t, 1));
        end
        wr(ADDR_WINDOW, 8'h7f);
        c0 = resCnt;
        wr(ADDR_CONTROL, 8'hff);
        cyc(3);
        chk(resCnt, c0);
        chk(watchdogActive, 1);
        wr(ADDR_WINDOW, 0);
        c0 = resCnt;
        wr(ADDR_CONTROL, 8'hff);
        waitRes(4);
        rd(ADDR_CONTROL, d); chk(d[7], 1);
        wr(ADDR_WINDOW, 8'h7f);
        wr(ADDR_CONTROL, 8'h7f);
        rd(ADDR_CONTROL, d); chk(d[7], 1);
        c0 = resCnt;
        wr(ADDR_CONTROL, 8'hc1);
        waitRes(2 * PS + 4);
        rd(ADDR_CONTROL, d); chk(d, 8'hbf);
        hwReset();
        rd(ADDR_CONTROL, d); chk(d, 8'h7f);
        hwWatchdogOption <= 1'b1;
        cyc(4);
        chk(watchdogActive, 1);
        c0 = resCnt;
        wr(ADDR_CONTROL, 8'h41);
        waitRes(2 * PS + 4);
        hwWatchdogOption <= 1'b0;
        hwReset();
        wr(ADDR_CONTROL, 8'hff);
        haltResetOption <= 1'b1;
        c0 = resCnt;
        haltCmd <= 1'b1;
        waitRes(8);
        {haltCmd, haltResetOption} <= 2'b00;
        hwReset();
        oscillatorIrqEnable <= 1'b1;
        wr(ADDR_CONTROL, 8'hc8);
        haltCmd <= 1'b1;
        cyc(6);
        rd(ADDR_CONTROL, d);
        c0 = resCnt;
        cyc(12 * PS);
        rd(ADDR_CONTROL, e); chk(e, d);
        chk(resCnt, c0);
        haltCmd <= 1'b0;
        wakeCmd <= 1'b1;
        cyc(4);
        wakeCmd <= 1'b0;
        waitRes(12 * PS);
        oscillatorIrqEnable <= 1'b0;
        wakeLongDelay <= 1'b1;
        hwReset();
        wr(ADDR_CONTROL, 8'hff);
        haltCmd <= 1'b1;
        cyc(3 * PS);
        rd(ADDR_CONTROL, d); chk(d[6:0] >= 7'h7d, 1);
        cyc(3 * PS);
        rd(ADDR_CONTROL, e); chk(e, d);
        {haltCmd, wakeCmd} <= 2'b01;
        cyc(4);
        wakeCmd <= 1'b0;
        cyc(20);
        rd(ADDR_CONTROL, e); chk(e, d);
        cyc(3 * PS);
        rd(ADDR_CONTROL, e); chk(e[6:0] < d[6:0], 1);
        haltCmd <= 1'b1;
        cyc(3 * PS);
        rstCmd <= 1'b1;
        cyc(4);
        {rstCmd, haltCmd} <= 2'b00;
        rd(ADDR_CONTROL, d); chk(d, 8'h7f);
        final_report();
    end
endmodule
